// file: rtl/smps_pin_select.sv
`timescale 1ns/1ps
`include "smps_consts.svh"

module smps_pin_select (
   input  wire logic                 clock_in,
   input  wire logic                 reset_n_in,
   input  wire logic                 reset_input_n_in,
   input  wire logic                 upper_mem_select_pin_in,
   input  wire logic                 lower_mem_select_pin_in,
   input  wire logic                 coprocessor_busy_pin_in,
   input  wire logic [1:0]           midrange_select_pin_in,
   input  wire smps_pkg::smps_cs_req_t cs_req_in,
   input  wire logic                 numeric_unit_request_in,
   input  wire logic                 crystal_drive_in,
   output logic                      upper_mem_select_n_out,
   output logic                      upper_mem_select_oe_out,
   output logic                      lower_mem_select_n_out,
   output logic                      lower_mem_select_oe_out,
   output logic [3:0]                midrange_select_n_out,
   output logic [3:0]                midrange_select_oe_out,
   output logic [3:0]                mid_wait_region_out,
   output logic                      extension_request_out,
   output logic                      coprocessor_error_out,
   output logic                      reset_out,
   output logic                      strap_pullup_en_out,
   output logic                      other_pins_oe_out,
   output logic                      crystal_output_out,
   output logic                      crystal_output_oe_out,
   output smps_pkg::smps_modes_t     modes_out
);
   import smps_pkg::*;

   smps_modes_t  modes;
   smps_pin_st_t s;
   smps_pin_st_t next_s;
   logic [1:0]   quarter;

   smps_strap_sampler u_straps (
      .clock_in                (clock_in),
      .reset_n_in              (reset_n_in),
      .reset_input_n_in        (reset_input_n_in),
      .upper_mem_select_pin_in (upper_mem_select_pin_in),
      .lower_mem_select_pin_in (lower_mem_select_pin_in),
      .coprocessor_busy_pin_in (coprocessor_busy_pin_in),
      .reset_out               (reset_out),
      .strap_pullup_en_out     (strap_pullup_en_out),
      .modes_out               (modes)
   );

   assign quarter = smps_quarter(cs_req_in.mid_offset, cs_req_in.mid_size_log2);

   always_comb begin
      next_s          = s;
      next_s.mid_meta = midrange_select_pin_in;
      next_s.mid_sync = s.mid_meta;
      next_s.crystal  = crystal_drive_in;
      if (modes.in_reset) begin
         // every select driven inactive, straps included
         next_s.ucs_n       = 1'h1;
         next_s.ucs_oe      = 1'h1;
         next_s.lcs_n       = 1'h1;
         next_s.lcs_oe      = 1'h1;
         next_s.mid_n       = 4'hF;
         next_s.mid_oe      = 4'hF;
         next_s.wait_region = 4'h0;
         next_s.other_oe    = 1'h1;
      end else if (modes.float_mode) begin
         next_s.ucs_n       = 1'h1;
         next_s.ucs_oe      = 1'h0;
         next_s.lcs_n       = 1'h1;
         next_s.lcs_oe      = 1'h0;
         next_s.mid_n       = 4'hF;
         next_s.mid_oe      = 4'h0;
         next_s.wait_region = 4'h0;
         next_s.other_oe    = 1'h0;
      end else begin
         next_s.ucs_n    = !cs_req_in.upper;
         next_s.ucs_oe   = 1'h1;
         next_s.lcs_n    = !cs_req_in.lower;
         next_s.lcs_oe   = 1'h1;
         next_s.other_oe = 1'h1;
         next_s.mid_oe   = 4'hF;
         for (int i = 0; i < 4; i++) begin
            // each select covers one quarter of the block
            next_s.mid_n[i]       = !(cs_req_in.mid_hit && quarter == 2'(i));
            next_s.wait_region[i] = cs_req_in.mid_hit && quarter == 2'(i);
         end
         if (modes.enhanced) begin
            // zero and one become coprocessor inputs, three its select
            next_s.mid_oe[`SMPS_MID_EXT_REQ]      = 1'h0;
            next_s.mid_oe[`SMPS_MID_ERROR]        = 1'h0;
            next_s.mid_n[`SMPS_MID_EXT_REQ]       = 1'h1;
            next_s.mid_n[`SMPS_MID_ERROR]         = 1'h1;
            next_s.mid_n[`SMPS_MID_NUM_SEL]       = !numeric_unit_request_in;
            next_s.wait_region[`SMPS_MID_EXT_REQ] = 1'h0;
            next_s.wait_region[`SMPS_MID_ERROR]   = 1'h0;
            next_s.wait_region[`SMPS_MID_NUM_SEL] = 1'h0;
            // select two keeps its wait and ready region unchanged
         end
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s <= '{mid_meta: 2'h3, mid_sync: 2'h3, ucs_n: 1'h1, ucs_oe: 1'h1,
                lcs_n: 1'h1, lcs_oe: 1'h1, mid_n: 4'hF, mid_oe: 4'hF,
                wait_region: 4'h0, other_oe: 1'h1, crystal: 1'h0};
      end else begin
         s <= next_s;
      end
   end

   assign upper_mem_select_n_out  = s.ucs_n;
   assign upper_mem_select_oe_out = s.ucs_oe;
   assign lower_mem_select_n_out  = s.lcs_n;
   assign lower_mem_select_oe_out = s.lcs_oe;
   assign midrange_select_n_out   = s.mid_n;
   assign midrange_select_oe_out  = s.mid_oe;
   assign mid_wait_region_out     = s.wait_region;
   // request pin is active high, error pin active low
   assign extension_request_out   = modes.enhanced && s.mid_sync[`SMPS_MID_EXT_REQ];
   assign coprocessor_error_out   = modes.enhanced && !s.mid_sync[`SMPS_MID_ERROR];
   assign other_pins_oe_out       = s.other_oe;
   assign crystal_output_out      = s.crystal;
   assign crystal_output_oe_out   = 1'h1;
   assign modes_out               = modes;

   a_reset_selects_high: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      modes.in_reset |=> (&s.mid_n && &s.mid_oe && s.ucs_n && s.ucs_oe
                          && s.lcs_n && s.lcs_oe))
      else $error("chip select not driven high during reset");

   a_float_pins_off: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (modes.float_mode && !modes.in_reset) |=>
         (s.mid_oe == 4'h0 && !s.ucs_oe && !s.lcs_oe && !other_pins_oe_out))
      else $error("pin driven in float mode");

   a_float_crystal_on: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      modes.float_mode |=>
         (crystal_output_oe_out && crystal_output_out == $past(crystal_drive_in)))
      else $error("crystal output floated");

   a_mid2_quarter: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      !s.mid_n[`SMPS_MID_KEPT] |->
         $past(cs_req_in.mid_hit) && $past(quarter) == 2'h2)
      else $error("select two outside its quarter");

   a_mid2_wait_kept: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!modes.in_reset && !modes.float_mode && cs_req_in.mid_hit && quarter == 2'h2)
         |=> mid_wait_region_out[`SMPS_MID_KEPT] && !s.mid_n[`SMPS_MID_KEPT])
      else $error("select two lost its region in a mode");

   a_enh_inputs_float: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (modes.enhanced && !modes.in_reset && !modes.float_mode) |=>
         (!s.mid_oe[`SMPS_MID_EXT_REQ] && !s.mid_oe[`SMPS_MID_ERROR]))
      else $error("coprocessor input pin driven");

   a_enh_numeric_sel: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (modes.enhanced && !modes.in_reset && !modes.float_mode) |=>
         s.mid_n[`SMPS_MID_NUM_SEL] == !$past(numeric_unit_request_in))
      else $error("numeric select does not follow request");

   a_ext_req_sync: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (modes.enhanced && $past(modes.enhanced, 2)) |->
         extension_request_out == $past(midrange_select_pin_in[0], 2))
      else $error("extension request not two-stage synchronised");

   a_float_kept: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      modes.float_mode |=>
         (modes.float_mode || modes.in_reset))
      else $error("float mode left without a reset");

   a_compat_driven: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!modes.in_reset && !modes.float_mode && !modes.enhanced) |=>
         (&s.mid_oe && s.ucs_oe && s.lcs_oe && other_pins_oe_out))
      else $error("select pin floated in compatible mode");

   a_enh_wait_two: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (modes.enhanced && !modes.in_reset && !modes.float_mode) |=>
         (mid_wait_region_out[3] == 1'h0 && mid_wait_region_out[1:0] == 2'h0))
      else $error("remapped select kept a wait region");

   a_copro_gated: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      !modes.enhanced |->
         (!extension_request_out && !coprocessor_error_out))
      else $error("coprocessor input seen outside enhanced mode");

   c_mid2_selected: cover property (
      @(posedge clock_in) disable iff (!reset_n_in)
      modes.enhanced ##1 !s.mid_n[`SMPS_MID_KEPT]);

   c_numeric_select: cover property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(s.mid_n[`SMPS_MID_NUM_SEL]) && modes.enhanced);

   c_float_floating: cover property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(other_pins_oe_out));

endmodule

// file: rtl/smps_consts.svh
`ifndef SMPS_CONSTS_SVH
`define SMPS_CONSTS_SVH

// mid-range select indices
`define SMPS_MID_EXT_REQ   0
`define SMPS_MID_ERROR     1
`define SMPS_MID_KEPT      2
`define SMPS_MID_NUM_SEL   3

// a quarter of the block is the block size shifted right by two
`define SMPS_QUARTER_SHIFT 5'h2

// reset output falls this many clocks after the synchronised reset pin rises
`define SMPS_RESET_OUT_LAG 2'h2

// strap level held by the internal pull-ups
`define SMPS_STRAP_IDLE    1'h1

`endif

// file: rtl/smps_pkg.sv
package smps_pkg;

   typedef struct packed {
      logic in_reset;
      logic enhanced;
      logic float_mode;
   } smps_modes_t;

   typedef struct packed {
      logic        upper;
      logic        lower;
      logic        mid_hit;
      logic [19:0] mid_offset;
      logic [4:0]  mid_size_log2;
   } smps_cs_req_t;

   typedef struct packed {
      logic       res_meta;
      logic       res_sync;
      logic       ucs_meta;
      logic       ucs_sync;
      logic       lcs_meta;
      logic       lcs_sync;
      logic       busy_meta;
      logic       busy_sync;
      logic [1:0] lag;
      logic       reset_out;
      logic       enhanced;
      logic       float_mode;
      logic       in_reset;
   } smps_strap_st_t;

   typedef struct packed {
      logic [1:0] mid_meta;
      logic [1:0] mid_sync;
      logic       ucs_n;
      logic       ucs_oe;
      logic       lcs_n;
      logic       lcs_oe;
      logic [3:0] mid_n;
      logic [3:0] mid_oe;
      logic [3:0] wait_region;
      logic       other_oe;
      logic       crystal;
   } smps_pin_st_t;

   // which quarter of the mid-range block an offset falls in
   function automatic logic [1:0] smps_quarter(input logic [19:0] off,
                                               input logic [4:0]  size_log2);
      logic [19:0] shifted;
      shifted = off >> (size_log2 - 5'h2);
      return shifted[1:0];
   endfunction

endpackage

// file: rtl/smps_strap_sampler.sv
`timescale 1ns/1ps
`include "smps_consts.svh"

module smps_strap_sampler (
   input  wire logic                 clock_in,
   input  wire logic                 reset_n_in,
   input  wire logic                 reset_input_n_in,
   input  wire logic                 upper_mem_select_pin_in,
   input  wire logic                 lower_mem_select_pin_in,
   input  wire logic                 coprocessor_busy_pin_in,
   output logic                      reset_out,
   output logic                      strap_pullup_en_out,
   output smps_pkg::smps_modes_t     modes_out
);
   import smps_pkg::*;

   smps_strap_st_t s;
   smps_strap_st_t next_s;

   always_comb begin
      next_s           = s;
      next_s.res_meta  = reset_input_n_in;
      next_s.res_sync  = s.res_meta;
      next_s.ucs_meta  = upper_mem_select_pin_in;
      next_s.ucs_sync  = s.ucs_meta;
      next_s.lcs_meta  = lower_mem_select_pin_in;
      next_s.lcs_sync  = s.lcs_meta;
      next_s.busy_meta = coprocessor_busy_pin_in;
      next_s.busy_sync = s.busy_meta;
      if (!s.res_sync) begin
         // reset applied again: leave float mode, drop held straps
         next_s.in_reset   = 1'h1;
         next_s.float_mode = 1'h0;
         next_s.enhanced   = 1'h0;
         next_s.lag        = `SMPS_RESET_OUT_LAG;
         next_s.reset_out  = 1'h1;
      end else begin
         if (s.in_reset) begin
            // rising edge of the reset pin: catch straps pins_float_test_mode
            next_s.in_reset   = 1'h0;
            next_s.float_mode = !s.ucs_sync && !s.lcs_sync;
            next_s.enhanced   = s.busy_sync;
         end
         if (s.lag != 2'h0) begin
            next_s.lag = s.lag - 2'h1;
         end
         next_s.reset_out = (s.lag > 2'h1);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s <= '{res_meta: 1'h0, res_sync: 1'h0,
                ucs_meta: `SMPS_STRAP_IDLE, ucs_sync: `SMPS_STRAP_IDLE,
                lcs_meta: `SMPS_STRAP_IDLE, lcs_sync: `SMPS_STRAP_IDLE,
                busy_meta: `SMPS_STRAP_IDLE, busy_sync: `SMPS_STRAP_IDLE,
                lag: `SMPS_RESET_OUT_LAG, reset_out: 1'h1, enhanced: 1'h0,
                float_mode: 1'h0, in_reset: 1'h1};
      end else begin
         s <= next_s;
      end
   end

   assign reset_out           = s.reset_out;
   assign strap_pullup_en_out = s.in_reset;
   assign modes_out           = '{in_reset: s.in_reset, enhanced: s.enhanced,
                                  float_mode: s.float_mode};

   a_float_strap_entry: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(s.in_reset) |-> s.float_mode == ($past(!s.ucs_sync) && $past(!s.lcs_sync)))
      else $error("float mode does not match sampled straps");

   a_modes_held: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!s.in_reset && $past(!s.in_reset)) |-> ($stable(s.float_mode) && $stable(s.enhanced)))
      else $error("latched modes changed outside reset");

   a_sample_on_rise: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(s.in_reset) |-> $past(s.res_sync) && $past(s.in_reset))
      else $error("straps taken without a reset pin rise");

   a_pullup_in_reset: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      !s.res_sync |=> strap_pullup_en_out)
      else $error("pull-ups off while reset applied");

   a_reset_out_lag: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(s.in_reset) |-> reset_out ##1 !reset_out)
      else $error("reset output not released two clocks after pin");

   c_float_entered: cover property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $rose(s.float_mode));

   c_enhanced_entered: cover property (
      @(posedge clock_in) disable iff (!reset_n_in)
      $rose(s.enhanced));

endmodule

// file: tb/smps_far_side.sv
`timescale 1ns/1ps
module smps_far_side (
   input  wire logic       clock_in,
   input  wire logic       reset_out_in,
   input  wire logic       pullup_en_in,
   input  wire logic [1:0] pin_n_in,
   input  wire logic [1:0] pin_oe_in,
   input  wire logic       tie_busy_in,
   input  wire logic [1:0] hold_low_in,
   input  wire logic       ext_req_in,
   input  wire logic       error_in,
   output logic      [1:0] strap_pin_out,
   output logic            busy_pin_out,
   output logic      [1:0] mid_pin_out
);
   logic [1:0] last;
   always_ff @(posedge clock_in) begin
      last <= strap_pin_out;
   end
   // fixture overpowers the device; an undriven pin without pull-up drifts
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (hold_low_in[i]) begin
            strap_pin_out[i] = 1'h0;
         end else if (pin_oe_in[i]) begin
            strap_pin_out[i] = pin_n_in[i];
         end else if (pullup_en_in) begin
            strap_pin_out[i] = 1'h1;
         end else begin
            strap_pin_out[i] = ~last[i];
         end
      end
   end
   assign busy_pin_out = tie_busy_in ? reset_out_in : 1'h0;
   // error pin is active low
   assign mid_pin_out = {~error_in, ext_req_in};
endmodule

// file: tb/strap_mode_pin_select_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module strap_mode_pin_select_test;
   import smps_pkg::*;
   typedef struct packed {logic [18:0] e; logic [18:0] m;} smps_note_t;
   int unsigned      err_count = 0;
   int unsigned      compares = 0;
   smps_note_t       q[$];
   smps_note_t       nt;
   logic             clk = 0, rst_n = 0, rst_pin = 0, numreq = 0, xd = 0;
   logic             tie = 0, pe = 0, pr = 0;
   logic       [1:0] hold = 0, straps, mid_p;
   logic             busy_p, un, uoe, ln, loe, ext, err, rout, pu, ooe, xo, xoe;
   logic       [3:0] mn, moe, mw;
   smps_cs_req_t     req = '0;
   smps_modes_t      md;
   logic      [18:0] obs;
   assign obs = {mn, moe, mw, un, uoe, ln, loe, ooe, xo, xoe};
   initial begin
      forever #10 clk = ~clk;
   end
   smps_far_side far_u (.clock_in(clk), .reset_out_in(rout), .pullup_en_in(pu),
      .pin_n_in({un, ln}), .pin_oe_in({uoe, loe}), .tie_busy_in(tie), .hold_low_in(hold),
      .ext_req_in(pe), .error_in(pr), .strap_pin_out(straps), .busy_pin_out(busy_p),
      .mid_pin_out(mid_p));
   smps_pin_select dut_u (.clock_in(clk), .reset_n_in(rst_n), .reset_input_n_in(rst_pin),
      .upper_mem_select_pin_in(straps[1]), .lower_mem_select_pin_in(straps[0]),
      .coprocessor_busy_pin_in(busy_p), .midrange_select_pin_in(mid_p), .cs_req_in(req),
      .numeric_unit_request_in(numreq), .crystal_drive_in(xd),
      .upper_mem_select_n_out(un), .upper_mem_select_oe_out(uoe),
      .lower_mem_select_n_out(ln), .lower_mem_select_oe_out(loe),
      .midrange_select_n_out(mn), .midrange_select_oe_out(moe),
      .mid_wait_region_out(mw), .extension_request_out(ext),
      .coprocessor_error_out(err), .reset_out(rout), .strap_pullup_en_out(pu),
      .other_pins_oe_out(ooe), .crystal_output_out(xo), .crystal_output_oe_out(xoe),
      .modes_out(md));
   task stop_test;
      if (err_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      #2;
      if (q.size() > 0) begin
         nt = q.pop_front();
         `CHK(obs & nt.m, nt.e & nt.m)
      end
   end
   task drive_cs(input int n, input bit enh, input bit flt, input bit rst);
      logic [3:0] hit;
      smps_note_t x;
      for (int k = 0; k < n; k++) begin
         @(negedge clk);
         req.upper = 1'($urandom);
         req.lower = 1'($urandom);
         req.mid_hit = 1'($urandom);
         req.mid_size_log2 = 5'(2 + $urandom % 18);
         req.mid_offset = 20'($urandom) & ((20'h1 << req.mid_size_log2) - 20'h1);
         numreq = 1'($urandom);
         xd = 1'($urandom);
         hit = req.mid_hit ? (4'h1 << ((req.mid_offset >> (req.mid_size_log2 - 5'h2)) & 3))
                           : 4'h0;
         x.m = '1;
         if (!rst_n) begin
            // crystal copy is cleared while the chip reset holds
            x.m[1] = 1'h0;
         end
         if (rst) begin
            x.e = {4'hF, 4'hF, 4'h0, 5'h1F, xd, 1'h1};
         end else if (flt) begin
            x.e = {12'h000, 5'h00, xd, 1'h1};
            x.m = {4'h0, 4'hF, 4'hF, 7'h2F};
         end else begin
            x.e = {~hit, 4'hF, hit, ~req.upper, 1'h1, ~req.lower, 2'h3, xd, 1'h1};
            if (enh) begin
               x.e[18:7] = {~numreq, ~hit[2], 2'h0, 4'hC, 1'h0, hit[2], 2'h0};
               x.m[16:15] = 2'h0;
            end
         end
         q.push_back(x);
      end
   endtask
   task enter(input bit hu, input bit hl, input bit t, input bit enh, input bit flt);
      int w;
      @(negedge clk);
      rst_pin = 0;
      hold = {hu, hl};
      tie = t;
      repeat (4) @(negedge clk);
      drive_cs(4, 0, 0, 1);
      `CHK(pu, 1'h1)
      @(negedge clk);
      rst_pin = 1;
      for (w = 0; w < 12 && md.in_reset !== 1'h0; w++) begin
         @(negedge clk);
      end
      if (w == 12) begin
         err_count++;
         stop_test();
      end
      `CHK(md, {1'h0, enh, flt})
      `CHK(pu, 1'h0)
      `CHK(rout, 1'h1)
      repeat (2) @(negedge clk);
      `CHK(rout, 1'h0)
      hold = 0;
   endtask
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
   initial begin
      void'($urandom(84));
      repeat (3) @(negedge clk);
      drive_cs(3, 0, 0, 1);
      rst_n = 1;
      enter(0, 0, 0, 0, 0);
      drive_cs(40, 0, 0, 0);
      hold = 2'h3;
      drive_cs(6, 0, 0, 0);
      `CHK(md, 3'h0)
      hold = 0;
      pe = 1;
      pr = 1;
      repeat (4) @(negedge clk);
      `CHK({ext, err}, 2'h0)
      enter(0, 0, 1, 1, 0);
      drive_cs(40, 1, 0, 0);
      repeat (4) @(negedge clk);
      `CHK({ext, err}, 2'h3)
      pe = 0;
      pr = 0;
      repeat (4) @(negedge clk);
      `CHK({ext, err}, 2'h0)
      enter(1, 1, 0, 0, 1);
      drive_cs(30, 0, 1, 0);
      `CHK(md.float_mode, 1'h1)
      enter(1, 0, 0, 0, 0);
      drive_cs(10, 0, 0, 0);
      enter(0, 1, 0, 0, 0);
      @(negedge clk);
      rst_n = 0;
      drive_cs(3, 0, 0, 1);
      `CHK(md, 3'h4)
      stop_test();
   end
endmodule
